// ===== swrc_sleep_wake_reset_control.sv
// Sleep, wake and reset controller with serial command link
//
// Contract
// - Power-up loads register defaults and starts in sleep mode.
// - Wake command bit set moves sleep to operation mode.
// - Standby command bit set returns operation mode to sleep.
// - Entering sleep resets the channel register to its default; interrupt mask keeps its value, interrupt status keeps its bits and gains the reset event.
// - Sleep via serial commands; losing logic supply forces sleep.
// - Every reset switches all channels off and restores the channel register default; only the reset input restores the interrupt registers.
// - Any reset sets the transmission error flag.
// - During undervoltage reset, reads return diagnostic frame with error flag; while the logic supply is lost, so stays low with so_oe off.
// - Undervoltage reset releases only when all supplies are above threshold.
// - Reset command bit immediately resets the channel register and diagnosis.
// - Serial shift path works whenever the logic supply is good.
// - Reset asserted within 1 us after logic supply undervoltage.
`timescale 1ns/1ps
`include "swrc_consts.svh"

module swrc_sleep_wake_reset_control
	import swrc_pkg::*;
#(
	parameter int WAKE_CYCLES =
		`SWRC_WAKE_UP_TIME_US * 1000 / `SWRC_CLK_PERIOD_NS,
	parameter int CHANNELS = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Supply monitors
	input wire logic vdd_ok,
	input wire logic vbb_ok,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Register port
	input wire logic [`SWRC_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Device outputs
	output logic [CHANNELS-1:0] channel_on,
	output logic awake_state_bit,
	output logic irq
);
	localparam int UV_MAX_CYCLES =
		`SWRC_LOGIC_UV_DELAY_US * 1000 / `SWRC_CLK_PERIOD_NS;
	localparam int FW = `SWRC_FRAME_W;

	function automatic logic [31:0] reg_read(
		input logic [`SWRC_ADDR_W-1:0] a,
		input logic [CHANNELS-1:0] ch,
		input swrc_status_t st,
		input logic [2:0] is,
		input logic [2:0] im
	);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			`SWRC_REG_CHAN: v[CHANNELS-1:0] = ch;
			`SWRC_REG_STATUS: v[2:0] = st;
			`SWRC_REG_IRQ_STAT: v[2:0] = is;
			`SWRC_REG_IRQ_MASK: v[2:0] = im;
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	// Two-flop synchronisers for pins
	swrc_pins_t pins_meta_r;
	swrc_pins_t pins_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			pins_meta_r <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0,
				vdd_ok: 1'b0, vbb_ok: 1'b0};
			pins_r <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0,
				vdd_ok: 1'b0, vbb_ok: 1'b0};
		end else begin
			pins_meta_r <= '{sclk: sclk, cs_n: cs_n, si: si,
				vdd_ok: vdd_ok, vbb_ok: vbb_ok};
			pins_r <= pins_meta_r;
		end
	end

	// Edge history of link signals
	logic sclk_d_r;
	logic cs_n_d_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			sclk_d_r <= 1'b0;
			cs_n_d_r <= 1'b1;
		end else begin
			sclk_d_r <= pins_r.sclk;
			cs_n_d_r <= pins_r.cs_n;
		end
	end
	logic sclk_rise;
	logic sclk_fall;
	logic cs_start;
	logic cs_end;
	assign sclk_rise = pins_r.sclk & ~sclk_d_r & ~pins_r.cs_n;
	assign sclk_fall = ~pins_r.sclk & sclk_d_r & ~pins_r.cs_n;
	assign cs_start = ~pins_r.cs_n & cs_n_d_r;
	assign cs_end = pins_r.cs_n & ~cs_n_d_r;

	// Undervoltage reset, released only with both supplies good
	logic uv_r;
	logic uv_nxt;
	assign uv_nxt = ~(pins_r.vdd_ok & pins_r.vbb_ok);
	always_ff @(posedge clk) begin
		if (reset) begin
			uv_r <= 1'b1;
		end else begin
			uv_r <= uv_nxt;
		end
	end
	logic logic_uv;
	assign logic_uv = ~pins_r.vdd_ok;

	// Command decode of completed frames
	logic [FW-1:0] shift_r;
	logic [$clog2(FW+1)-1:0] bit_cnt_r;
	logic frame_cmd;
	assign frame_cmd = cs_end & ~uv_r
		& (bit_cnt_r == ($clog2(FW+1))'(FW))
		& shift_r[`SWRC_FRAME_CMD_BIT];
	logic reg_cmd;
	assign reg_cmd = wr & (addr == `SWRC_REG_CMD) & ~uv_r;
	logic cmd_wake;
	logic cmd_standby;
	logic cmd_reset;
	assign cmd_wake = (frame_cmd & shift_r[`SWRC_CMD_WAKE_BIT])
		| (reg_cmd & wdata[`SWRC_CMD_WAKE_BIT]);
	assign cmd_standby = (frame_cmd & shift_r[`SWRC_CMD_STANDBY_BIT])
		| (reg_cmd & wdata[`SWRC_CMD_STANDBY_BIT]);
	assign cmd_reset = (frame_cmd & shift_r[`SWRC_CMD_RESET_BIT])
		| (reg_cmd & wdata[`SWRC_CMD_RESET_BIT]);

	// Operating state
	swrc_state_t state_r;
	logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt_r;
	logic enter_sleep;
	assign enter_sleep = (state_r != SWRC_SLEEP)
		& (cmd_standby | logic_uv);
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= SWRC_SLEEP;
			wake_cnt_r <= '0;
		end else if (uv_r) begin
			state_r <= SWRC_SLEEP;
			wake_cnt_r <= '0;
		end else begin
			case (state_r)
				SWRC_SLEEP: begin
					if (cmd_wake & ~cmd_standby) begin
						state_r <= SWRC_WAKING;
						wake_cnt_r <= '0;
					end
				end
				SWRC_WAKING: begin
					if (cmd_standby) begin
						state_r <= SWRC_SLEEP;
					end else if (wake_cnt_r ==
						($clog2(WAKE_CYCLES+1))'(WAKE_CYCLES - 1)) begin
						state_r <= SWRC_ON;
					end else begin
						wake_cnt_r <= wake_cnt_r + 1'b1;
					end
				end
				SWRC_ON: begin
					if (cmd_standby) begin
						state_r <= SWRC_SLEEP;
					end
				end
				default: state_r <= SWRC_SLEEP;
			endcase
		end
	end

	// Any reset source
	logic any_reset;
	assign any_reset = uv_r | cmd_reset | enter_sleep;

	// Channel register
	logic [CHANNELS-1:0] chan_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			chan_r <= CHANNELS'(`SWRC_CHAN_RESET);
		end else if (any_reset) begin
			chan_r <= CHANNELS'(`SWRC_CHAN_RESET);
		end else if (wr & (addr == `SWRC_REG_CHAN)
			& (state_r == SWRC_ON)) begin
			chan_r <= wdata[CHANNELS-1:0];
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			channel_on <= '0;
		end else begin
			channel_on <= any_reset ? '0 : chan_r;
		end
	end

	// Transmission error flag, set wins over clear
	logic ter_r;
	logic frame_done;
	assign frame_done = cs_end & ~uv_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			ter_r <= 1'b1;
		end else if (any_reset) begin
			ter_r <= 1'b1;
		end else if (frame_done) begin
			ter_r <= 1'b0;
		end
	end

	// Serial shift path; only logic supply loss stops it
	logic [FW-1:0] diag_frame;
	assign diag_frame = {ter_r | uv_r, state_r == SWRC_ON, uv_r,
		(FW-3)'(0)};
	always_ff @(posedge clk) begin
		if (reset | logic_uv) begin
			shift_r <= '0;
			bit_cnt_r <= '0;
		end else if (cs_start) begin
			shift_r <= diag_frame;
			bit_cnt_r <= '0;
		end else if (sclk_rise) begin
			shift_r <= {shift_r[FW-2:0], pins_r.si};
			if (bit_cnt_r != ($clog2(FW+1))'(FW)) begin
				bit_cnt_r <= bit_cnt_r + 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (reset | logic_uv) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else begin
			so_oe <= ~pins_r.cs_n;
			if (cs_start) begin
				so <= diag_frame[FW-1];
			end else if (sclk_fall) begin
				so <= shift_r[FW-1];
			end
		end
	end

	// Awake status output
	always_ff @(posedge clk) begin
		if (reset) begin
			awake_state_bit <= 1'b0;
		end else begin
			awake_state_bit <= (state_r == SWRC_ON);
		end
	end

	// Interrupt status and mask
	logic [2:0] irq_stat_r;
	logic [2:0] irq_mask_r;
	logic [2:0] irq_evt;
	logic uv_d_r;
	logic on_d_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			uv_d_r <= 1'b1;
			on_d_r <= 1'b0;
		end else begin
			uv_d_r <= uv_r;
			on_d_r <= (state_r == SWRC_ON);
		end
	end
	always_comb begin
		irq_evt = 3'h0;
		irq_evt[`SWRC_IRQ_RESET_BIT] = any_reset & ~uv_r;
		irq_evt[`SWRC_IRQ_AWAKE_BIT] = (state_r == SWRC_ON) & ~on_d_r;
		irq_evt[`SWRC_IRQ_UV_BIT] = uv_r & ~uv_d_r;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_stat_r <= 3'h0;
		end else if (wr & (addr == `SWRC_REG_IRQ_STAT)) begin
			irq_stat_r <= (irq_stat_r & ~wdata[2:0]) | irq_evt;
		end else begin
			irq_stat_r <= irq_stat_r | irq_evt;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_mask_r <= `SWRC_IRQ_MASK_RESET;
		end else if (wr & (addr == `SWRC_REG_IRQ_MASK)) begin
			irq_mask_r <= wdata[2:0];
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Register read port
	swrc_status_t status;
	assign status = '{uv_active: uv_r, transmission_error_flag: ter_r,
		awake_state_bit: state_r == SWRC_ON};
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 32'h0;
		end else if (rd) begin
			rdata <= reg_read(addr, chan_r, status, irq_stat_r,
				irq_mask_r);
		end else begin
			rdata <= 32'h0;
		end
	end
endmodule

// ===== swrc_consts.svh
// Constants for the sleep, wake and reset controller
`ifndef SWRC_CONSTS_SVH
`define SWRC_CONSTS_SVH
`define SWRC_CLK_PERIOD_NS 10
`define SWRC_WAKE_UP_TIME_US 200
`define SWRC_LOGIC_UV_DELAY_US 1
`define SWRC_BATT_UV_DELAY_US 1
`define SWRC_ADDR_W 8
`define SWRC_REG_CMD 8'h00
`define SWRC_REG_CHAN 8'h04
`define SWRC_REG_STATUS 8'h08
`define SWRC_REG_IRQ_STAT 8'h0C
`define SWRC_REG_IRQ_MASK 8'h10
`define SWRC_CMD_WAKE_BIT 0
`define SWRC_CMD_STANDBY_BIT 1
`define SWRC_CMD_RESET_BIT 2
`define SWRC_FRAME_W 8
`define SWRC_FRAME_CMD_BIT 7
`define SWRC_CHAN_RESET 8'h00
`define SWRC_IRQ_MASK_RESET 3'h0
`define SWRC_IRQ_RESET_BIT 0
`define SWRC_IRQ_AWAKE_BIT 1
`define SWRC_IRQ_UV_BIT 2
`endif

// ===== swrc_pkg.sv
// Types for the sleep, wake and reset controller
package swrc_pkg;
	typedef enum logic [1:0] {
		SWRC_SLEEP,
		SWRC_WAKING,
		SWRC_ON
	} swrc_state_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic si;
		logic vdd_ok;
		logic vbb_ok;
	} swrc_pins_t;

	typedef struct packed {
		logic uv_active;
		logic transmission_error_flag;
		logic awake_state_bit;
	} swrc_status_t;
endpackage

// ===== swrc_asserts.sv
// Assertions for the sleep, wake and reset controller
`timescale 1ns/1ps
`include "swrc_consts.svh"
module swrc_asserts #(
	parameter int CHANNELS = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Supplies and register port
	input wire logic vdd_ok,
	input wire logic vbb_ok,
	input wire logic [`SWRC_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	// Device outputs
	input wire logic [CHANNELS-1:0] channel_on,
	input wire logic awake_state_bit
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence cmd_wr(b);
		wr && addr == `SWRC_REG_CMD && wdata[b];
	endsequence
	sequence uv_low;
		(!vdd_ok || !vbb_ok) [*6];
	endsequence
	AST_RST_OFF: assert property ($fell(reset) |->
		channel_on == '0 && !awake_state_bit) else $error("reset exit");
	AST_ASLEEP_OFF: assert property (!awake_state_bit |->
		channel_on == '0) else $error("channel on in sleep");
	AST_STANDBY: assert property (cmd_wr(`SWRC_CMD_STANDBY_BIT) |->
		##[1:4] (!awake_state_bit && channel_on == '0))
		else $error("standby ignored");
	AST_RST_CMD: assert property (cmd_wr(`SWRC_CMD_RESET_BIT) |->
		##[1:4] channel_on == '0) else $error("reset command ignored");
	AST_VDD_UV: assert property ($fell(vdd_ok) |-> ##[1:100]
		(channel_on == '0 && !awake_state_bit)) else $error("uv slow");
	AST_UV_HOLD: assert property (uv_low |->
		channel_on == '0 && !awake_state_bit) else $error("uv released");
	AST_UV_TER: assert property (uv_low ##0 rd &&
		addr == `SWRC_REG_STATUS |=> rdata[1] && rdata[2])
		else $error("uv read");
	AST_WAKE_TIME: assert property ($rose(awake_state_bit) |->
		!$past(awake_state_bit, 16)) else $error("wake too fast");
endmodule
bind swrc_sleep_wake_reset_control swrc_asserts #(.CHANNELS(CHANNELS))
	i_chk (.clk, .reset, .vdd_ok, .vbb_ok, .addr, .wdata, .wr, .rd,
	.rdata, .channel_on, .awake_state_bit);

// ===== swrc_spi_master.sv
// Serial master model sending command frames
`timescale 1ns/1ps
module swrc_spi_master #(
	parameter realtime HALF = 62.5
) (
	// Link
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			si = tx[i];
			#HALF;
			rx[i] = so;
			sclk = 1'b1;
			#HALF;
			sclk = 1'b0;
		end
		#HALF;
		cs_n = 1'b1;
		si = ~si;
		#(4 * HALF);
	endtask
endmodule

// ===== swrc_sleep_wake_reset_control_tb.sv
// Self-checking bench for the sleep, wake and reset controller
`timescale 1ns/1ps
module swrc_sleep_wake_reset_control_tb;
	logic clk, reset, vdd_ok, vbb_ok, sclk, cs_n, si, so, so_oe;
	logic wr, rd, rd_d, awake_state_bit, irq;
	logic [7:0] addr, rx, ch, channel_on;
	logic [31:0] wdata, rdata;
	logic [31:0] exp_q[$];
	int seed, fail_count, n_tests;
	swrc_sleep_wake_reset_control #(.WAKE_CYCLES(20)) i_dut (.clk, .reset,
		.vdd_ok, .vbb_ok, .sclk, .cs_n, .si, .so, .so_oe, .addr, .wdata,
		.wr, .rd, .rdata, .channel_on, .awake_state_bit, .irq);
	swrc_spi_master i_spi (.sclk, .cs_n, .si, .so);
	always #5 clk = ~clk;
	task automatic check(input string s, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		if (!w) exp_q.push_back(d);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_awake;
		for (int k = 0; k < 200 && awake_state_bit !== 1'b1; k++) begin
			@(posedge clk);
		end
		check("awake", 32'(awake_state_bit), 32'h1);
		if (awake_state_bit !== 1'b1) test_done;
	endtask
	always @(posedge clk) begin
		rd_d <= rd;
		if (rd_d === 1'b1) begin
			check("rdata", rdata, exp_q.pop_front());
		end
	end
	initial begin
		{clk, reset, vdd_ok, vbb_ok, wr, rd} = 6'h1C;
		addr = 8'h00;
		wdata = 32'h0;
		seed = 32'hF2C3;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		repeat (6) @(posedge clk);
		bus(0, 8'h08, 32'h2);
		bus(1, 8'h04, 32'hFF);
		bus(0, 8'h04, 32'h0);
		bus(0, 8'h14, 32'h0);
		$display("power-up done");
		i_spi.xfer(8'h81, rx);
		@(posedge clk);
		check("frame", 32'(rx), 32'h80);
		check("so_oe", 32'(so_oe), 32'h0);
		wait_awake;
		bus(0, 8'h08, 32'h1);
		ch = 8'($random(seed));
		bus(1, 8'h04, 32'(ch));
		bus(0, 8'h04, 32'(ch));
		check("chan", 32'(channel_on), 32'(ch));
		check("irq", 32'(irq), 32'h0);
		bus(1, 8'h10, 32'h2);
		@(posedge clk);
		check("irq", 32'(irq), 32'h1);
		bus(1, 8'h0C, 32'h2);
		@(posedge clk);
		check("irq", 32'(irq), 32'h0);
		$display("wake done");
		bus(1, 8'h00, 32'h4);
		bus(0, 8'h04, 32'h0);
		check("chan", 32'(channel_on), 32'h0);
		bus(1, 8'h00, 32'h1);
		wait_awake;
		bus(0, 8'h08, 32'h3);
		$display("reset command done");
		ch = 8'($random(seed));
		bus(1, 8'h04, 32'(ch));
		bus(1, 8'h00, 32'h3);
		bus(0, 8'h04, 32'h0);
		bus(0, 8'h08, 32'h2);
		$display("standby done");
		vbb_ok <= 1'b0;
		repeat (6) @(posedge clk);
		i_spi.xfer(8'h81, rx);
		@(posedge clk);
		check("frame", 32'(rx), 32'hA0);
		vdd_ok <= 1'b0;
		repeat (6) @(posedge clk);
		bus(0, 8'h08, 32'h6);
		vdd_ok <= 1'b1;
		repeat (6) @(posedge clk);
		bus(0, 8'h08, 32'h6);
		vbb_ok <= 1'b1;
		repeat (6) @(posedge clk);
		bus(0, 8'h08, 32'h2);
		$display("undervoltage done");
		test_done;
	end
endmodule
